// ### hw/port_pkg.sv
// Constants, types and register map for the expanded port block.
// Assumes one clock and a synchronous active-high reset in every user.
// Notes on behaviour
// - Ports four and five have latches that act like standard port latches.
// - Control/status register is CPU read/write except bits 1:0, which are read-only.
// - Reset sets control/status bits 7:2 to one and clears bits 1:0.
// - B flag field 7:6: low, high, input-full, or active-low port-enable input.
// - A flag field 5:4: low, high, output-full, or register-select input.
// - Bit 3 picks output strobe edge clearing output-full: 0 falling, 1 rising.
// - Bit 2: 0 captures on input strobe rise; 1 latch follows while strobe low.
// - Bit 1 reads 1 while the output buffer holds unacknowledged data.
// - Bit 0 reads 1 while the input buffer holds unread data.
// - B high bit 0 with A field 10 drives port always; strobe only clears.
// - Ports four and five are plain quasi-bidirectional ports.
// - Small package variant has only the low four bits of port four.
// - Grounded control pins with reset state give a plain port, no setup.
// - Reset state is bus interface mode and must not disturb a host bus.
package port_pkg;
    localparam logic [7:0] ADDR_P4 = 8'hc0;
    localparam logic [7:0] ADDR_P5 = 8'hc8;
    localparam logic [7:0] ADDR_P6 = 8'hd8;
    localparam logic [7:0] ADDR_CSR = 8'he8;
    localparam logic [7:0] CSR_RESET = 8'hfc;
    localparam logic [7:0] LATCH_RESET = 8'hff;
    localparam int CSR_OBF = 1;
    localparam int CSR_IBF = 0;
    localparam int CSR_MODE_LSB = 2;
    localparam logic [1:0] FLAG_LOW = 2'h0;
    localparam logic [1:0] FLAG_HIGH = 2'h1;
    localparam logic [1:0] FLAG_STATUS = 2'h2;
    localparam logic [1:0] FLAG_INPUT = 2'h3;
    localparam int FIFO_DEPTH = 16;
    localparam int P4_WIDTH = 8;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_t;

    // Writable upper six bits of the control/status register
    typedef struct packed {
        logic [1:0] bmode;
        logic [1:0] amode;
        logic out_full_clear_edge;
        logic in_strobe_sense;
    } p6_mode_t;

    typedef struct packed {
        logic ids_n;
        logic ods_n;
        logic fa;
        logic fb;
        logic [7:0] data;
    } p6_pins_t;
endpackage

// ### hw/quasi_port.sv
// Quasi-bidirectional port: latch, weak-high pins, filtered pin read.
// Assumes pins come from outside the clock domain.
`timescale 1ns/1ps
module quasi_port #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // CPU side
    input wire logic wr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] latch,
    output logic [W-1:0] pin_val,
    // Pins
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] pin_o,
    output logic [W-1:0] pin_oe
);
    logic [W-1:0] latch_ff, nxt_latch;
    logic [W-1:0] s1_ff, s2_ff, s3_ff, filt_ff, nxt_filt;

    always_comb begin
        nxt_latch = wr ? wdata : latch_ff;
        nxt_filt = (~(s2_ff ^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & filt_ff);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            latch_ff <= W'(port_pkg::LATCH_RESET);
            s1_ff <= '1;
            s2_ff <= '1;
            s3_ff <= '1;
            filt_ff <= '1;
        end else begin
            latch_ff <= nxt_latch;
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= nxt_filt;
        end
    end

    // Only a zero is driven; a one is left to the pull-up so the pin reads as input
    assign latch = latch_ff;
    assign pin_val = filt_ff;
    assign pin_o = '0;
    assign pin_oe = ~latch_ff;

    AST_LATCH_WR: assert property (@(posedge ref_clk) disable iff (srst)
        wr |=> (latch == $past(wdata)) && (pin_oe == ~$past(wdata)))
        else $error("port latch did not take CPU write");
endmodule

// ### hw/strobed_parallel_port_csr.sv
// Ports four, five and the strobed port six with its control/status register.
// Assumes a CPU special-function bus on ref_clk; all pins are asynchronous.
`timescale 1ns/1ps
module strobed_parallel_port_csr #(
    parameter int P4W = port_pkg::P4_WIDTH,
    parameter int DEPTH = port_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // CPU special-function access
    input wire port_pkg::sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // Port four pins
    input wire logic [P4W-1:0] p4_i,
    output logic [P4W-1:0] p4_o,
    output logic [P4W-1:0] p4_oe,
    // Port five pins
    input wire logic [7:0] p5_i,
    output logic [7:0] p5_o,
    output logic [7:0] p5_oe,
    // Port six data pins
    input wire logic [7:0] p6_i,
    output logic [7:0] p6_o,
    output logic [7:0] p6_oe,
    // Port six strobes, active low
    input wire logic input_data_strobe_n,
    input wire logic output_data_strobe_n,
    // Port six flag pins
    input wire logic flag_pin_a_i,
    output logic flag_pin_a_o,
    output logic flag_pin_a_oe,
    input wire logic flag_pin_b_i,
    output logic flag_pin_b_o,
    output logic flag_pin_b_oe
);
    port_pkg::p6_pins_t raw, s1_ff, s2_ff, s3_ff, filt_ff, prev_ff, nxt_filt;
    port_pkg::p6_mode_t mode;
    logic [7:0] p4_val8, p5_val, p5_latch;
    logic [P4W-1:0] p4_val, p4_latch;
    logic wr_p4, wr_p5, wr_p6, wr_csr, rd_p6;
    logic pe_active, reg_sel, data_acc, csr_acc, out_always, host_read;
    logic ids_rise, ods_rise, ods_fall, ods_clr_edge;
    logic input_buffer_full, fifo_in_ready, fifo_push, fifo_pop;
    logic [7:0] fifo_head, csr_view;
    logic [5:0] csr_ff, nxt_csr;
    logic output_buffer_full_ff, nxt_obf;
    logic [7:0] out_buf_ff, nxt_out_buf, in_latch_ff, nxt_in_latch;
    logic [7:0] rdata_ff, nxt_rdata, p6_o_ff, nxt_p6_o;
    logic p6_en_ff, nxt_p6_en;
    logic fa_o_ff, fa_oe_ff, fb_o_ff, fb_oe_ff;
    logic nxt_fa_o, nxt_fa_oe, nxt_fb_o, nxt_fb_oe;

    // CPU decode
    assign wr_p4 = sfr_req.wr & (sfr_req.addr == port_pkg::ADDR_P4);
    assign wr_p5 = sfr_req.wr & (sfr_req.addr == port_pkg::ADDR_P5);
    assign wr_p6 = sfr_req.wr & (sfr_req.addr == port_pkg::ADDR_P6);
    assign wr_csr = sfr_req.wr & (sfr_req.addr == port_pkg::ADDR_CSR);
    assign rd_p6 = sfr_req.rd & (sfr_req.addr == port_pkg::ADDR_P6);

    // Ports four and five
    quasi_port #(.W(P4W)) u_port_four (
        .ref_clk(ref_clk),
        .srst(srst),
        .wr(wr_p4),
        .wdata(sfr_req.wdata[P4W-1:0]),
        .latch(p4_latch),
        .pin_val(p4_val),
        .pin_i(p4_i),
        .pin_o(p4_o),
        .pin_oe(p4_oe)
    );

    quasi_port #(.W(8)) u_port_five (
        .ref_clk(ref_clk),
        .srst(srst),
        .wr(wr_p5),
        .wdata(sfr_req.wdata),
        .latch(p5_latch),
        .pin_val(p5_val),
        .pin_i(p5_i),
        .pin_o(p5_o),
        .pin_oe(p5_oe)
    );

    // Missing upper port-four bits read as zero in the narrow variant
    assign p4_val8 = 8'(p4_val);

    // Three-stage pin synchroniser; a change counts once stages two and three agree
    assign raw = '{ids_n: input_data_strobe_n, ods_n: output_data_strobe_n,
                   fa: flag_pin_a_i, fb: flag_pin_b_i, data: p6_i};

    always_comb begin
        nxt_filt = port_pkg::p6_pins_t'((~(s2_ff ^ s3_ff) & s2_ff)
                                       | ((s2_ff ^ s3_ff) & filt_ff));
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s1_ff <= '1;
            s2_ff <= '1;
            s3_ff <= '1;
            filt_ff <= '1;
            prev_ff <= '1;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= nxt_filt;
            prev_ff <= filt_ff;
        end
    end

    // Mode decode
    assign mode = port_pkg::p6_mode_t'(csr_ff);
    assign pe_active = (mode.bmode == port_pkg::FLAG_INPUT) ? ~filt_ff.fb : 1'b1;
    assign reg_sel = (mode.amode == port_pkg::FLAG_INPUT) ? filt_ff.fa : 1'b0;
    assign data_acc = pe_active & ~reg_sel;
    assign csr_acc = pe_active & reg_sel;
    assign out_always = ~mode.bmode[1] & (mode.amode == port_pkg::FLAG_STATUS);
    assign ids_rise = filt_ff.ids_n & ~prev_ff.ids_n;
    assign ods_rise = filt_ff.ods_n & ~prev_ff.ods_n;
    assign ods_fall = ~filt_ff.ods_n & prev_ff.ods_n;
    assign ods_clr_edge = mode.out_full_clear_edge ? ods_rise : ods_fall;
    assign host_read = pe_active & ~filt_ff.ods_n;
    assign csr_view = {csr_ff, output_buffer_full_ff, input_buffer_full};

    // Input buffer: a full FIFO refuses further strobes rather than overwrite
    assign fifo_push = data_acc & ids_rise;
    assign fifo_pop = rd_p6;

    sync_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_in_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(filt_ff.data),
        .out_valid(input_buffer_full),
        .out_ready(fifo_pop),
        .out_data(fifo_head)
    );

    // Control/status, buffers and flags
    always_comb begin
        nxt_csr = csr_ff;
        if (csr_acc & ids_rise) begin
            nxt_csr = filt_ff.data[7:port_pkg::CSR_MODE_LSB];
        end
        if (wr_csr) begin
            nxt_csr = sfr_req.wdata[7:port_pkg::CSR_MODE_LSB];
        end
        nxt_obf = output_buffer_full_ff;
        if (data_acc & ods_clr_edge) begin
            nxt_obf = 1'b0;
        end
        if (wr_p6) begin
            nxt_obf = 1'b1;
        end
        nxt_out_buf = wr_p6 ? sfr_req.wdata : out_buf_ff;
        nxt_in_latch = in_latch_ff;
        if (mode.in_strobe_sense & data_acc & ~filt_ff.ids_n) begin
            nxt_in_latch = filt_ff.data;
        end
        // Live latch answers when nothing is buffered, so grounded strobes read the pins
        case (sfr_req.addr)
            port_pkg::ADDR_P4: nxt_rdata = p4_val8;
            port_pkg::ADDR_P5: nxt_rdata = p5_val;
            port_pkg::ADDR_P6: nxt_rdata = input_buffer_full ? fifo_head : in_latch_ff;
            port_pkg::ADDR_CSR: nxt_rdata = csr_view;
            default: nxt_rdata = 8'h00;
        endcase
        if (!sfr_req.rd) begin
            nxt_rdata = rdata_ff;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            csr_ff <= port_pkg::CSR_RESET[7:port_pkg::CSR_MODE_LSB];
            output_buffer_full_ff <= 1'b0;
            out_buf_ff <= port_pkg::LATCH_RESET;
            in_latch_ff <= port_pkg::LATCH_RESET;
            rdata_ff <= 8'h00;
        end else begin
            csr_ff <= nxt_csr;
            output_buffer_full_ff <= nxt_obf;
            out_buf_ff <= nxt_out_buf;
            in_latch_ff <= nxt_in_latch;
            rdata_ff <= nxt_rdata;
        end
    end

    // Pin drivers; in reset state nothing is driven unless the host enables and strobes
    always_comb begin
        nxt_p6_en = out_always | host_read;
        nxt_p6_o = (host_read & reg_sel) ? csr_view : out_buf_ff;
        case (mode.bmode)
            port_pkg::FLAG_LOW: nxt_fb_o = 1'b0;
            port_pkg::FLAG_HIGH: nxt_fb_o = 1'b1;
            port_pkg::FLAG_STATUS: nxt_fb_o = input_buffer_full;
            default: nxt_fb_o = 1'b0;
        endcase
        nxt_fb_oe = (mode.bmode != port_pkg::FLAG_INPUT);
        case (mode.amode)
            port_pkg::FLAG_LOW: nxt_fa_o = 1'b0;
            port_pkg::FLAG_HIGH: nxt_fa_o = 1'b1;
            port_pkg::FLAG_STATUS: nxt_fa_o = output_buffer_full_ff;
            default: nxt_fa_o = 1'b0;
        endcase
        nxt_fa_oe = (mode.amode != port_pkg::FLAG_INPUT);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            p6_en_ff <= 1'b0;
            p6_o_ff <= 8'hff;
            fa_o_ff <= 1'b0;
            fa_oe_ff <= 1'b0;
            fb_o_ff <= 1'b0;
            fb_oe_ff <= 1'b0;
        end else begin
            p6_en_ff <= nxt_p6_en;
            p6_o_ff <= nxt_p6_o;
            fa_o_ff <= nxt_fa_o;
            fa_oe_ff <= nxt_fa_oe;
            fb_o_ff <= nxt_fb_o;
            fb_oe_ff <= nxt_fb_oe;
        end
    end

    assign p6_o = p6_o_ff;
    assign p6_oe = {8{p6_en_ff}};
    assign flag_pin_a_o = fa_o_ff;
    assign flag_pin_a_oe = fa_oe_ff;
    assign flag_pin_b_o = fb_o_ff;
    assign flag_pin_b_oe = fb_oe_ff;
    assign sfr_rdata = rdata_ff;

    AST_CSR_RESET: assert property (@(posedge ref_clk) disable iff (srst)
        $past(srst) |-> (csr_view == 8'hfc) && !p6_en_ff)
        else $error("control/status not at reset value after reset");
    AST_CSR_RO: assert property (@(posedge ref_clk) disable iff (srst)
        wr_csr && !wr_p6 && !(data_acc && ods_clr_edge) |=>
        (csr_ff == $past(sfr_req.wdata[7:2]))
        && (output_buffer_full_ff == $past(output_buffer_full_ff)))
        else $error("control/status write wrong or touched read-only bit");
    AST_FLAG_PIN_B: assert property (@(posedge ref_clk) disable iff (srst)
        mode.bmode == port_pkg::FLAG_STATUS |=> fb_oe_ff && fb_o_ff == $past(input_buffer_full))
        else $error("B flag does not show input-full");
    AST_FLAG_PIN_A: assert property (@(posedge ref_clk) disable iff (srst)
        mode.amode == port_pkg::FLAG_INPUT |=> !fa_oe_ff)
        else $error("A flag driven while it is select input");
    AST_OBF_CLR: assert property (@(posedge ref_clk) disable iff (srst)
        data_acc && ods_clr_edge && !wr_p6 |=> !output_buffer_full_ff && csr_view[1] == 1'b0)
        else $error("output-full not cleared by selected strobe edge");
    AST_LEVEL: assert property (@(posedge ref_clk) disable iff (srst)
        mode.in_strobe_sense && data_acc && !filt_ff.ids_n |=> in_latch_ff == $past(filt_ff.data))
        else $error("input latch not following in level mode");
    AST_OBF_SET: assert property (@(posedge ref_clk) disable iff (srst)
        wr_p6 |=> output_buffer_full_ff && out_buf_ff == $past(sfr_req.wdata))
        else $error("data write did not load buffer and set output-full");
    AST_IBF: assert property (@(posedge ref_clk) disable iff (srst)
        fifo_push && fifo_in_ready && !fifo_pop |=> input_buffer_full && csr_view[0])
        else $error("captured byte did not set input-full");
    AST_ALWAYS: assert property (@(posedge ref_clk) disable iff (srst)
        out_always |=> p6_oe == 8'hff)
        else $error("output-always mode not driving port");
    AST_SAFE: assert property (@(posedge ref_clk) disable iff (srst)
        !out_always && !host_read |=> p6_oe == 8'h00)
        else $error("port drives the bus without enable and strobe");
    AST_HOST_CSR: assert property (@(posedge ref_clk) disable iff (srst)
        csr_acc && ids_rise && !wr_csr |=> csr_ff == $past(filt_ff.data[7:2]))
        else $error("host control/status write lost");

    // Port-enable, pin drive and read-path checks
    AST_PE_OFF: assert property (@(posedge ref_clk) disable iff (srst)
        (mode.bmode == port_pkg::FLAG_INPUT) && filt_ff.fb && !rd_p6
        |=> input_buffer_full == $past(input_buffer_full))
        else $error("disabled port took a host strobe");
    AST_FLAG_PIN_B_LOW: assert property (@(posedge ref_clk) disable iff (srst)
        mode.bmode == port_pkg::FLAG_LOW |=> fb_oe_ff && !fb_o_ff)
        else $error("B flag not driven low");
    AST_FLAG_PIN_A_HIGH: assert property (@(posedge ref_clk) disable iff (srst)
        mode.amode == port_pkg::FLAG_HIGH |=> fa_oe_ff && fa_o_ff)
        else $error("A flag not driven high");
    AST_OUT_DATA: assert property (@(posedge ref_clk) disable iff (srst)
        host_read && !reg_sel |=> p6_o == $past(out_buf_ff))
        else $error("port six not showing the output buffer");
    AST_OUT_CSR: assert property (@(posedge ref_clk) disable iff (srst)
        host_read && reg_sel |=> p6_o == $past(csr_view))
        else $error("port six not showing control/status");
    AST_RD_FIFO: assert property (@(posedge ref_clk) disable iff (srst)
        rd_p6 && input_buffer_full |=> sfr_rdata == $past(fifo_head))
        else $error("data read did not return the oldest buffered byte");
    AST_RD_P4: assert property (@(posedge ref_clk) disable iff (srst)
        sfr_req.rd && (sfr_req.addr == port_pkg::ADDR_P4) |=> sfr_rdata == $past(p4_val8))
        else $error("port four read did not return its pins");
    AST_QUASI_OE: assert property (@(posedge ref_clk) disable iff (srst)
        (p4_oe == ~p4_latch) && (p5_oe == ~p5_latch))
        else $error("quasi port drives low where its latch is high");

    COV_HOST_WRITE: cover property (@(posedge ref_clk) disable iff (srst) fifo_push ##[1:20] rd_p6);
    COV_HOST_READ: cover property (@(posedge ref_clk) disable iff (srst)
        wr_p6 ##[1:20] (data_acc && ods_clr_edge));
    COV_FIFO_FULL: cover property (@(posedge ref_clk) disable iff (srst) !fifo_in_ready);
    COV_ALWAYS: cover property (@(posedge ref_clk) disable iff (srst) out_always && ods_fall);
    COV_PE_BLOCKED: cover property (@(posedge ref_clk) disable iff (srst)
        (mode.bmode == port_pkg::FLAG_INPUT) && filt_ff.fb && ids_rise);
endmodule

// ### hw/sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem[rptr_ff];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        nxt_wptr = push ? ((wptr_ff == AW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1) : wptr_ff;
        nxt_rptr = pop ? ((rptr_ff == AW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1) : rptr_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage needs no reset; only valid entries are ever read
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wptr_ff] <= in_data;
        end
    end
endmodule

// ### testbench/host_bus_model.sv
// Far-end model of port six: host data lines, strobes, select and enable.
// Assumes the device's pin drivers come in here; released lines float high.
`timescale 1ns/1ps
module host_bus_model (
    // Clock
    input wire logic ref_clk,
    // Device drivers
    input wire logic [7:0] p6_o,
    input wire logic [7:0] p6_oe,
    input wire logic fa_o,
    input wire logic fa_oe,
    input wire logic fb_o,
    input wire logic fb_oe,
    // Resolved lines
    output logic [7:0] p6_line,
    output logic fa_line,
    output logic fb_line,
    output logic ids_n,
    output logic ods_n
);
    logic drv, sel, pe_n;
    logic [7:0] data;
    initial begin
        drv = 1'b0;
        sel = 1'b0;
        pe_n = 1'b1;
        data = 8'h00;
        ids_n = 1'b1;
        ods_n = 1'b1;
    end
    // Pull-ups win only where nobody drives
    assign p6_line = drv ? data : (p6_oe & p6_o) | ~p6_oe;
    assign fa_line = fa_oe ? fa_o : sel;
    assign fb_line = fb_oe ? fb_o : pe_n;
    task automatic set_ctl(input logic s, input logic p);
        @(posedge ref_clk);
        sel <= s;
        pe_n <= p;
    endtask
    // Strobes held 8 cycles, well over the device filter's 3
    task automatic ids_low(input logic [7:0] d);
        @(posedge ref_clk);
        drv <= 1'b1;
        data <= d;
        ids_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic ids_high();
        @(posedge ref_clk);
        ids_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        drv <= 1'b0;
    endtask
    task automatic ods_set(input logic lvl);
        @(posedge ref_clk);
        ods_n <= lvl;
        repeat (8) @(posedge ref_clk);
        // Leave the edge so callers sample settled lines
        #1;
    endtask
endmodule

// ### testbench/test_strobed_parallel_port_csr.sv
// Self-checking bench for the expanded port block with a host model on port six.
// Assumes one 25 MHz clock; quasi port pins are pulled up outside.
`timescale 1ns/1ps
module test_strobed_parallel_port_csr;
    logic ref_clk, srst, ids_n, ods_n, fa_o, fa_oe, fb_o, fb_oe, fa_line, fb_line;
    port_pkg::sfr_req_t sfr_req;
    logic [7:0] sfr_rdata, p4_o, p4_oe, p5_o, p5_oe, p6_o, p6_oe, p6_line;
    logic [7:0] p4_ext, p5_ext, p4_pin, p5_pin;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    // Address, write data, read-back value
    logic [23:0] rows [6] = '{24'hc0a5a5, 24'hc83c3c, 24'hc0ffff, 24'he83330,
                              24'he8fffc, 24'h807700};
    // Outside drivers only pull low; the port's own low drive wins
    assign p4_pin = p4_ext & ~p4_oe;
    assign p5_pin = p5_ext & ~p5_oe;

    strobed_parallel_port_csr u_strobed_parallel_port_csr (
        .ref_clk(ref_clk), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .p4_i(p4_pin), .p4_o(p4_o), .p4_oe(p4_oe),
        .p5_i(p5_pin), .p5_o(p5_o), .p5_oe(p5_oe),
        .p6_i(p6_line), .p6_o(p6_o), .p6_oe(p6_oe),
        .input_data_strobe_n(ids_n), .output_data_strobe_n(ods_n),
        .flag_pin_a_i(fa_line), .flag_pin_a_o(fa_o), .flag_pin_a_oe(fa_oe),
        .flag_pin_b_i(fb_line), .flag_pin_b_o(fb_o), .flag_pin_b_oe(fb_oe)
    );
    host_bus_model u_host_bus_model (
        .ref_clk(ref_clk), .p6_o(p6_o), .p6_oe(p6_oe),
        .fa_o(fa_o), .fa_oe(fa_oe), .fb_o(fb_o), .fb_oe(fb_oe),
        .p6_line(p6_line), .fa_line(fa_line), .fb_line(fb_line),
        .ids_n(ids_n), .ods_n(ods_n)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_req <= '{a, 1'b1, 1'b0, d};
        @(posedge ref_clk);
        sfr_req.wr <= 1'b0;
    endtask
    // Read data is registered: settled just after the edge that takes rd
    task automatic rd_is(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge ref_clk);
        sfr_req.rd <= 1'b0;
        #1;
        check(sfr_rdata, exp);
    endtask
    task automatic host_push(input logic [7:0] d);
        u_host_bus_model.ids_low(d);
        u_host_bus_model.ids_high();
    endtask

    initial begin
        srst = 1'b1;
        sfr_req = '0;
        p4_ext = 8'hff;
        p5_ext = 8'hff;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        // Pins need the filter delay before a port read
        foreach (rows[i]) begin
            sfr_wr(rows[i][23:16], rows[i][15:8]);
            repeat (8) @(posedge ref_clk);
            rd_is(rows[i][23:16], rows[i][7:0]);
        end
        // Outside pulls low where the latches leave the pins high
        @(posedge ref_clk);
        p4_ext <= 8'h5a;
        p5_ext <= 8'h0f;
        repeat (8) @(posedge ref_clk);
        rd_is(8'hc0, 8'h5a);
        rd_is(8'hc8, 8'h0c);
        check(p5_oe, 8'hc3);
        @(posedge ref_clk);
        p4_ext <= 8'hff;
        p5_ext <= 8'hff;
        sfr_wr(8'hc0, 8'h00);
        sfr_wr(8'he8, 8'h00);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        check(p6_oe, 8'h00);
        check({6'h0, fa_oe, fb_oe}, 8'h00);
        check(p4_oe, 8'h00);
        repeat (8) @(posedge ref_clk);
        rd_is(8'he8, 8'hfc);
        rd_is(8'hc0, 8'hff);
        u_host_bus_model.set_ctl(1'b0, 1'b0);
        u_host_bus_model.ids_low(8'h71);
        rd_is(8'hd8, 8'h71);
        rd_is(8'he8, 8'hfc);
        u_host_bus_model.ids_high();
        rd_is(8'he8, 8'hfd);
        rd_is(8'hd8, 8'h71);
        rd_is(8'he8, 8'hfc);
        sfr_wr(8'he8, 8'hf8);
        u_host_bus_model.ids_low(8'h2e);
        rd_is(8'hd8, 8'h71);
        u_host_bus_model.ids_high();
        rd_is(8'hd8, 8'h2e);
        u_host_bus_model.set_ctl(1'b0, 1'b1);
        host_push(8'h55);
        rd_is(8'he8, 8'hf8);
        u_host_bus_model.set_ctl(1'b1, 1'b0);
        host_push(8'hf4);
        rd_is(8'he8, 8'hf4);
        u_host_bus_model.ods_set(1'b0);
        check(p6_line, 8'hf4);
        u_host_bus_model.ods_set(1'b1);
        u_host_bus_model.set_ctl(1'b0, 1'b0);
        // Seventeenth byte must be dropped by the full buffer
        for (int i = 0; i < 17; i++) host_push(8'h10 + i[7:0]);
        rd_is(8'he8, 8'hf5);
        for (int i = 0; i < 16; i++) rd_is(8'hd8, 8'h10 + i[7:0]);
        rd_is(8'he8, 8'hf4);
        sfr_wr(8'hd8, 8'h3c);
        rd_is(8'he8, 8'hf6);
        u_host_bus_model.ods_set(1'b0);
        check(p6_line, 8'h3c);
        rd_is(8'he8, 8'hf4);
        u_host_bus_model.ods_set(1'b1);
        check(p6_oe, 8'h00);
        sfr_wr(8'he8, 8'hfc);
        sfr_wr(8'hd8, 8'hc3);
        u_host_bus_model.ods_set(1'b0);
        check(p6_line, 8'hc3);
        rd_is(8'he8, 8'hfe);
        u_host_bus_model.ods_set(1'b1);
        rd_is(8'he8, 8'hfc);
        host_push(8'h66);
        sfr_wr(8'hd8, 8'h99);
        // Host pulls both flags high so a driven low is visible
        u_host_bus_model.set_ctl(1'b1, 1'b1);
        for (int c = 0; c < 3; c++) begin
            sfr_wr(8'he8, {c[1:0], c[1:0], 4'hc});
            repeat (3) @(posedge ref_clk);
            #1;
            check({7'h0, fb_line}, {7'h0, c != 0});
            check({7'h0, fa_line}, {7'h0, c != 0});
        end
        sfr_wr(8'he8, 8'h6c);
        repeat (3) @(posedge ref_clk);
        #1;
        check(p6_oe, 8'hff);
        check(p6_line, 8'h99);
        u_host_bus_model.ods_set(1'b0);
        u_host_bus_model.ods_set(1'b1);
        check({7'h0, fa_line}, 8'h00);
        check(p6_oe, 8'hff);
        sfr_wr(8'he8, 8'hfc);
        rd_is(8'hd8, 8'h66);
        u_host_bus_model.set_ctl(1'b0, 1'b0);
        u_host_bus_model.ods_set(1'b0);
        u_host_bus_model.ids_low(8'ha9);
        rd_is(8'hd8, 8'ha9);
        complete_run();
    end
endmodule
